// file: hdl/atmr_pkg.sv
// constants and types shared by the autoreload timer files
package atmr_pkg;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_CNT_HIGH    = 8'h01;
  localparam logic [7:0] OFF_CNT_LOW     = 8'h02;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'h03;
  localparam logic [7:0] OFF_RELOAD_LOW  = 8'h04;
  localparam logic [7:0] OFF_PWM_ENABLES = 8'h05;
  localparam logic [7:0] OFF_CHAN_CSR0   = 8'h06;  // channel i at OFF_CHAN_CSR0 + i
  localparam logic [7:0] OFF_DUTY_LOW0   = 8'h0a;  // channel i low at + 2*i, high at + 2*i + 1
  localparam logic [7:0] OFF_CAP_HIGH    = 8'h12;
  localparam logic [7:0] OFF_CAP_LOW     = 8'h13;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CS_CAP_FLAG_BIT  = 6;
  localparam int CS_CAP_IE_BIT    = 5;
  localparam int CS_CKSEL_LSB     = 3;
  localparam int CS_OVF_FLAG_BIT  = 2;
  localparam int CS_OVF_IE_BIT    = 1;
  localparam int CS_CMP_IE_BIT    = 0;
  localparam int CH_POL_BIT       = 1;
  localparam int CH_FLAG_BIT      = 0;
  localparam int OE_STRIDE        = 2;   // enable of channel i sits at bit 2*i

  // -----------------------------------------------------------------
  // counter values, reset values and clock rates
  // -----------------------------------------------------------------
  localparam int          CNT_W       = 12;
  localparam logic [11:0] CNT_MAX     = 12'hfff;
  localparam logic [11:0] CNT_RESET   = 12'h000;
  localparam logic [11:0] RELOAD_RST  = 12'h000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam int          CLK_MHZ     = 100;
  localparam int          FAST_MHZ    = 32;
  localparam logic [7:0]  FAST_STEP   = 8'(FAST_MHZ);
  localparam logic [7:0]  FAST_MOD    = 8'(CLK_MHZ);

  // counter clock selection codes
  typedef enum logic [1:0] {
    CK_OFF  = 2'h0,
    CK_LITE = 2'h1,
    CK_CPU  = 2'h2,
    CK_FAST = 2'h3
  } atmr_cksel_t;

endpackage : atmr_pkg

// file: hdl/atmr_tick.sv
// counter tick generator for the four clock selections
`timescale 1ns/1ps
module atmr_tick (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire atmr_pkg::atmr_cksel_t sel,
  input  wire logic                lite_timebase_clock,
  output logic                     tick
);
  import atmr_pkg::*;

  typedef struct packed {
    logic       lite_prev;
    logic [7:0] acc;
    logic       tick;
  } atmr_tick_st_t;

  atmr_tick_st_t q;
  atmr_tick_st_t d;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // fast rate by fractional accumulation: 32 ticks per 100 clocks
  always_comb begin
    logic [7:0] sum;
    sum         = q.acc + FAST_STEP;
    d           = q;
    d.lite_prev = lite_timebase_clock;
    d.tick      = 1'b0;
    unique case (sel)
      CK_OFF:  d.tick = 1'b0;
      CK_LITE: d.tick = lite_timebase_clock & ~q.lite_prev;
      CK_CPU:  d.tick = 1'b1;
      CK_FAST: begin
        if (sum >= FAST_MOD) begin
          d.acc  = sum - FAST_MOD;
          d.tick = 1'b1;
        end else begin
          d.acc  = sum;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : atmr_tick

// file: hdl/atmr_chan.sv
// one pwm channel: compare flag, level, polarity and pin enable
`timescale 1ns/1ps
module atmr_chan (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        tick,
  input  wire logic        wrap,
  input  wire logic [11:0] next_cnt,
  input  wire logic [11:0] duty,
  input  wire logic        enable,
  input  wire logic        polarity,
  input  wire logic        read_clear,
  input  wire logic        pwm_allowed,
  output logic             compare_flag,
  output logic             pwm_out,
  output logic             pwm_oe
);
  import atmr_pkg::*;

  typedef struct packed {
    logic flag;
    logic level;
    logic pin;
    logic oe;
  } atmr_chan_st_t;

  atmr_chan_st_t q;
  atmr_chan_st_t d;
  logic          match;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // compare and pwm are suspended on the lite timebase selection
  assign match = tick & pwm_allowed & (next_cnt == duty);

  always_comb begin
    d = q;
    if (read_clear) begin
      d.flag = 1'b0;
    end
    if (match) begin
      d.flag = 1'b1;
    end
    if (tick && pwm_allowed && wrap) begin
      d.level = 1'b1;
    end
    if (match) begin
      d.level = 1'b0;
    end
    if (enable) begin
      d.oe = 1'b1;
    end else if (wrap) begin
      d.oe = 1'b0;
    end
    d.pin = d.level ^ polarity;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign compare_flag = q.flag;
  assign pwm_out      = q.pin;
  assign pwm_oe       = q.oe;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_CMP_SET: assert property (@(posedge clk) disable iff (!reset_n)
    match |=> q.flag) else $error("compare flag not set on match");
  AST_POL_APPLY: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (q.pin == (q.level ^ $past(polarity)))) else $error("polarity not applied");
  AST_OE_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (q.oe && !enable && !wrap) |=> q.oe) else $error("pin enable dropped before overflow");

endmodule : atmr_chan

// file: hdl/atmr_timer.sv
// 12-bit autoreload timer with input capture and four pwm channels
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module atmr_timer #(
  parameter int CHANNELS = 4
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  input  wire logic        capture_input_pin,
  input  wire logic        lite_timebase_clock,
  output logic      [3:0]  pwm_out,
  output logic      [3:0]  pwm_oe,
  output logic             capture_irq,
  output logic             overflow_irq,
  output logic             compare_irq
);
  import atmr_pkg::*;

  // -----------------------------------------------------------------
  // configuration check
  // -----------------------------------------------------------------
  if (CHANNELS != 4) begin : g_bad_channels
    $error("atmr_timer serves exactly four channels");
  end

  typedef struct packed {
    logic [11:0]      cnt;
    logic [11:0]      reload;
    logic [3:0]       cnt_hi_latch;
    logic [11:0]      capture;
    logic             cap_prev;
    logic             cap_flag;
    logic             cap_ie;
    atmr_cksel_t      cksel;
    logic             ovf_flag;
    logic             ovf_ie;
    logic             cmp_ie;
    logic [3:0]       pwm_en;
    logic [3:0]       pol;
    logic [3:0][11:0] duty;
    logic [7:0]       rdata;
    logic             cap_irq;
    logic             ovf_irq;
    logic             cmp_irq;
  } atmr_st_t;

  atmr_st_t    q;
  atmr_st_t    d;
  logic        tick;
  logic        wrap;
  logic [11:0] next_cnt;
  logic        cap_event;
  logic        pwm_allowed;
  logic [3:0]  chan_flag;
  logic [3:0]  chan_rd_clr;
  logic [3:0]  chan_pin;
  logic [3:0]  chan_oe;

  // -----------------------------------------------------------------
  // counter clock
  // -----------------------------------------------------------------
  atmr_tick u_tick (
    .clk                 (clk),
    .reset_n             (reset_n),
    .sel                 (q.cksel),
    .lite_timebase_clock (lite_timebase_clock),
    .tick                (tick)
  );

  // counter step and wrap to the reload value
  assign wrap        = tick & (q.cnt == CNT_MAX);
  assign next_cnt    = wrap ? q.reload : q.cnt + 12'h001;
  assign cap_event   = capture_input_pin & ~q.cap_prev;
  assign pwm_allowed = (q.cksel != CK_LITE);

  // -----------------------------------------------------------------
  // pwm channels
  // -----------------------------------------------------------------
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    assign chan_rd_clr[i] = rd_en & (addr == OFF_CHAN_CSR0 + 8'(i));
    atmr_chan u_chan (
      .clk          (clk),
      .reset_n      (reset_n),
      .tick         (tick),
      .wrap         (wrap),
      .next_cnt     (next_cnt),
      .duty         (q.duty[i]),
      .enable       (q.pwm_en[i]),
      .polarity     (q.pol[i]),
      .read_clear   (chan_rd_clr[i]),
      .pwm_allowed  (pwm_allowed),
      .compare_flag (chan_flag[i]),
      .pwm_out      (chan_pin[i]),
      .pwm_oe       (chan_oe[i])
    );
  end

  // -----------------------------------------------------------------
  // next state: counter, flags, register writes and reads
  // -----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.cap_prev = capture_input_pin;
    if (tick) begin
      d.cnt = next_cnt;
    end
    // capture flag: read clears, a new capture in the same cycle wins
    if (rd_en && (addr == OFF_CAP_HIGH || addr == OFF_CAP_LOW)) begin
      d.cap_flag = 1'b0;
    end
    if (cap_event) begin
      d.capture  = q.cnt;
      d.cap_flag = 1'b1;
    end
    // overflow flag: status read clears, overflow in the same cycle wins
    if (rd_en && addr == OFF_CTRL_STATUS) begin
      d.ovf_flag = 1'b0;
    end
    if (wrap) begin
      d.ovf_flag = 1'b1;
    end
    // latch the high nibble on a low byte read so the pair is coherent
    if (rd_en && addr == OFF_CNT_LOW) begin
      d.cnt_hi_latch = q.cnt[11:8];
    end
    // software writes; flag bits and counter are not writable
    if (wr_en) begin
      unique case (addr)
        OFF_CTRL_STATUS: begin
          d.cap_ie = wdata[CS_CAP_IE_BIT];
          d.cksel  = atmr_cksel_t'(wdata[CS_CKSEL_LSB +: 2]);
          d.ovf_ie = wdata[CS_OVF_IE_BIT];
          d.cmp_ie = wdata[CS_CMP_IE_BIT];
        end
        OFF_RELOAD_HIGH: d.reload[11:8] = wdata[3:0];
        OFF_RELOAD_LOW:  d.reload[7:0]  = wdata;
        OFF_PWM_ENABLES: begin
          for (int i = 0; i < 4; i++) begin
            d.pwm_en[i] = wdata[OE_STRIDE * i];
          end
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr == OFF_CHAN_CSR0 + 8'(i)) begin
              d.pol[i] = wdata[CH_POL_BIT];
            end
            if (addr == OFF_DUTY_LOW0 + 8'(2 * i)) begin
              d.duty[i][7:0] = wdata;
            end
            if (addr == OFF_DUTY_LOW0 + 8'(2 * i + 1)) begin
              d.duty[i][11:8] = wdata[3:0];
            end
          end
        end
      endcase
    end
    // read data stands in the cycle after the strobe only
    d.rdata = BYTE_ZERO;
    if (rd_en) begin
      unique case (addr)
        OFF_CTRL_STATUS: begin
          d.rdata[CS_CAP_FLAG_BIT]        = q.cap_flag;
          d.rdata[CS_CAP_IE_BIT]          = q.cap_ie;
          d.rdata[CS_CKSEL_LSB +: 2]      = q.cksel;
          d.rdata[CS_OVF_FLAG_BIT]        = q.ovf_flag;
          d.rdata[CS_OVF_IE_BIT]          = q.ovf_ie;
          d.rdata[CS_CMP_IE_BIT]          = q.cmp_ie;
        end
        OFF_CNT_HIGH:    d.rdata = {4'h0, q.cnt_hi_latch};
        OFF_CNT_LOW:     d.rdata = q.cnt[7:0];
        OFF_RELOAD_HIGH: d.rdata = {4'h0, q.reload[11:8]};
        OFF_RELOAD_LOW:  d.rdata = q.reload[7:0];
        OFF_CAP_HIGH:    d.rdata = {4'h0, q.capture[11:8]};
        OFF_CAP_LOW:     d.rdata = q.capture[7:0];
        OFF_PWM_ENABLES: begin
          for (int i = 0; i < 4; i++) begin
            d.rdata[OE_STRIDE * i] = q.pwm_en[i];
          end
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr == OFF_CHAN_CSR0 + 8'(i)) begin
              d.rdata[CH_POL_BIT]  = q.pol[i];
              d.rdata[CH_FLAG_BIT] = chan_flag[i];
            end
            if (addr == OFF_DUTY_LOW0 + 8'(2 * i)) begin
              d.rdata = q.duty[i][7:0];
            end
            if (addr == OFF_DUTY_LOW0 + 8'(2 * i + 1)) begin
              d.rdata = {4'h0, q.duty[i][11:8]};
            end
          end
        end
      endcase
    end
    // interrupt levels follow flag and enable one cycle later
    d.cap_irq = q.cap_flag & q.cap_ie;
    d.ovf_irq = q.ovf_flag & q.ovf_ie;
    d.cmp_irq = (|chan_flag) & q.cmp_ie;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q        <= '0;
      q.cnt    <= CNT_RESET;
      q.reload <= RELOAD_RST;
      q.cksel  <= CK_OFF;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rdata        = q.rdata;
  assign capture_irq  = q.cap_irq;
  assign overflow_irq = q.ovf_irq;
  assign compare_irq  = q.cmp_irq;
  assign pwm_out      = chan_pin;
  assign pwm_oe       = chan_oe;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_stopped;
    (q.cksel == CK_OFF) [*2];
  endsequence

  sequence s_top_tick;
    tick && (q.cnt == CNT_MAX);
  endsequence

  sequence s_cap_pending;
    q.cap_flag && q.cap_ie;
  endsequence

  AST_CAP_FLAG_SET: assert property (@(posedge clk) disable iff (!reset_n)
    cap_event |=> q.cap_flag) else $error("capture flag not set");
  AST_CAP_FLAG_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_en && addr == OFF_CAP_LOW && !cap_event) |=> !q.cap_flag) else $error("capture flag not cleared");
  AST_CAP_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    cap_event |=> (q.capture == $past(q.cnt))) else $error("capture value wrong");
  AST_CAP_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (capture_irq == ($past(q.cap_flag) && $past(q.cap_ie)))) else $error("capture irq wrong");
  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    s_stopped |=> $stable(q.cnt)) else $error("counter moved while off");
  AST_INCREMENT: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && q.cnt != CNT_MAX) |=> (q.cnt == $past(q.cnt) + 12'h001)) else $error("counter step wrong");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
    s_top_tick |=> (q.cnt == $past(q.reload)) && q.ovf_flag) else $error("reload or overflow wrong");
  AST_OVF_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_en && addr == OFF_CTRL_STATUS && !wrap) |=> !q.ovf_flag) else $error("overflow flag not cleared");
  AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
    (q.ovf_flag && q.ovf_ie) [*2] |-> overflow_irq) else $error("overflow irq missing");
  AST_CMP_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
    !q.cmp_ie |=> !compare_irq) else $error("compare irq not masked");
  AST_CNT_HI_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_en && addr == OFF_CNT_HIGH) |=> (rdata[7:4] == 4'h0)) else $error("counter high nibble not zero");
  // interrupt lines hold while flag and enable stand, and drop when masked
  AST_CAP_IRQ_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    s_cap_pending [*2] |-> capture_irq) else $error("capture irq dropped");
  AST_CMP_IRQ_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    ((|chan_flag) && q.cmp_ie) [*2] |-> compare_irq) else $error("compare irq dropped");
  AST_OVF_IRQ_MASK: assert property (@(posedge clk) disable iff (!reset_n)
    !q.ovf_ie |=> !overflow_irq) else $error("overflow irq not masked");
  // status writes land in the select field and never touch the hardware flags
  AST_CKSEL_WR: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_en && addr == OFF_CTRL_STATUS) |=> (q.cksel == $past(wdata[CS_CKSEL_LSB +: 2])))
    else $error("clock select not written");
  AST_FLAG_NO_WR: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_en && !rd_en && addr == OFF_CTRL_STATUS && !cap_event && !wrap) |=>
    (q.cap_flag == $past(q.cap_flag) && q.ovf_flag == $past(q.ovf_flag))) else $error("status flag written");
  AST_LITE_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    !pwm_allowed |=> ((chan_flag & ~$past(chan_flag)) == 4'h0)) else $error("compare active on timebase");

endmodule : atmr_timer

// file: testbench/atmr_pin_model.sv
// far-side pin model: capture input source and timebase line
`timescale 1ns/1ps
module atmr_pin_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic       lite_en,
  input  wire logic [3:0] pwm_out,
  input  wire logic [3:0] pwm_oe,
  output logic            capture_input_pin,
  output logic            lite_timebase_clock
);
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic [2:0] hold_q;
  logic [1:0] div_q;

  // pins idle low; the timebase stands still until lite_en is raised
  initial begin
    capture_input_pin   = 1'b0;
    lite_timebase_clock = 1'b0;
    hold_q              = 3'h0;
    div_q               = 2'h0;
  end

  // timebase: one full period every eight clocks while enabled, low otherwise
  always @(posedge clk) begin
    if (!lite_en) begin
      div_q               <= 2'h0;
      lite_timebase_clock <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        lite_timebase_clock <= ~lite_timebase_clock;
      end
    end
  end

  // a fire request gives one clean rising edge, held a few cycles
  always @(posedge clk) begin
    if (fire) begin
      hold_q            <= 3'h3;
      capture_input_pin <= 1'b1;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      capture_input_pin <= 1'b0;
    end
  end
endmodule : atmr_pin_model

// file: testbench/atmr_timer_tb_top.sv
// self-checking bench for the autoreload timer
`timescale 1ns/1ps
module atmr_timer_tb_top;
  import atmr_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic       clk;
  logic       reset_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       fire;
  logic       lite_en;
  logic       cap_pin;
  logic       lite_clk;
  logic [3:0] pwm_out;
  logic [3:0] pwm_oe;
  logic       capture_irq;
  logic       overflow_irq;
  logic       compare_irq;
  int         mismatches;
  int         cmp_count;

  atmr_timer #(.CHANNELS(4)) uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .capture_input_pin(cap_pin), .lite_timebase_clock(lite_clk),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .capture_irq(capture_irq), .overflow_irq(overflow_irq),
    .compare_irq(compare_irq));

  atmr_pin_model pins (.clk(clk), .fire(fire), .lite_en(lite_en), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .capture_input_pin(cap_pin), .lite_timebase_clock(lite_clk));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, d, exp);
  endtask : rdchk

  // bounded wait for one of the interrupt lines: 0 overflow, 1 compare, 2 capture
  task automatic wait_hi(input int w);
    for (int n = 0; n < 6000; n++) begin
      @(posedge clk);
      #1;
      if ((w == 0 && overflow_irq === 1'b1) || (w == 1 && compare_irq === 1'b1) ||
          (w == 2 && capture_irq === 1'b1)) return;
    end
    mismatches++;
    stop_test();
  endtask : wait_hi

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rdchk(OFF_CTRL_STATUS, 8'h00, "status");
    rdchk(OFF_CNT_LOW, 8'h00, "cnt_low");
    rdchk(OFF_RELOAD_HIGH, 8'h00, "reload_hi");
    rdchk(OFF_PWM_ENABLES, 8'h00, "enables");
    rdchk(OFF_CHAN_CSR0, 8'h00, "ch0_csr");
    chk("pwm_oe", {4'h0, pwm_oe}, 8'h00);
    chk("pwm_out", {4'h0, pwm_out}, 8'h00);
  endtask : t_reset

  task automatic t_regs();
    wr(OFF_RELOAD_HIGH, 8'hff);
    wr(OFF_RELOAD_LOW, 8'hfa);
    wr(OFF_CNT_LOW, 8'h55);
    rdchk(OFF_RELOAD_HIGH, 8'h0f, "reload_hi");
    rdchk(OFF_RELOAD_LOW, 8'hfa, "reload_lo");
    rdchk(OFF_CNT_LOW, 8'h00, "cnt_ro");
    rdchk(8'hff, 8'h00, "unmapped");
    wr(OFF_PWM_ENABLES, 8'hff);
    rdchk(OFF_PWM_ENABLES, 8'h55, "enables");
    wr(OFF_PWM_ENABLES, 8'h00);
    repeat (3) @(posedge clk);
    chk("oe_hold", {4'h0, pwm_oe}, 8'h0f);
  endtask : t_regs

  task automatic t_overflow();
    logic [7:0] lo;
    logic [7:0] hi;
    wr(OFF_CTRL_STATUS, 8'h12);
    repeat (4000) @(posedge clk);
    chk("ovf_early", {7'h0, overflow_irq}, 8'h00);
    wait_hi(0);
    wr(OFF_CTRL_STATUS, 8'h02);
    rdchk(OFF_CTRL_STATUS, 8'h06, "ovf_set");
    rdchk(OFF_CTRL_STATUS, 8'h02, "ovf_clr");
    chk("ovf_irq", {7'h0, overflow_irq}, 8'h00);
    rd(OFF_CNT_LOW, lo);
    rd(OFF_CNT_HIGH, hi);
    chk("cnt_hi", hi, 8'h0f);
    chk("cnt_reload", {7'h0, lo >= 8'hfa}, 8'h01);
  endtask : t_overflow

  task automatic t_pwm();
    logic [7:0] c;
    logic       lvl;
    wr(OFF_DUTY_LOW0, 8'hfd);
    wr(OFF_DUTY_LOW0 + 8'h01, 8'h0f);
    wr(OFF_PWM_ENABLES, 8'h01);
    wr(OFF_CTRL_STATUS, 8'h11);
    wait_hi(1);
    chk("oe_ch0", {4'h0, pwm_oe}, 8'h01);
    wr(OFF_CTRL_STATUS, 8'h01);
    rd(OFF_CNT_LOW, c);
    lvl = (c < 8'hfd);
    chk("pwm_lvl", {7'h0, pwm_out[0]}, {7'h0, lvl});
    wr(OFF_CHAN_CSR0, 8'h02);
    repeat (2) @(posedge clk);
    chk("pwm_inv", {7'h0, pwm_out[0]}, {7'h0, ~lvl});
    rdchk(OFF_CHAN_CSR0, 8'h03, "cmp_set");
    rdchk(OFF_CHAN_CSR0, 8'h02, "cmp_clr");
    chk("cmp_irq", {7'h0, compare_irq}, 8'h00);
    wr(OFF_CTRL_STATUS, 8'h10);
    repeat (20) @(posedge clk);
    chk("cmp_mask", {7'h0, compare_irq}, 8'h00);
  endtask : t_pwm

  task automatic t_capture();
    logic [7:0] hi;
    wr(OFF_CTRL_STATUS, 8'h30);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_hi(2);
    chk("ovf_gate", {7'h0, overflow_irq}, 8'h00);
    wr(OFF_CTRL_STATUS, 8'h20);
    rdchk(OFF_CTRL_STATUS, 8'h64, "cap_keep");
    rdchk(OFF_CTRL_STATUS, 8'h60, "cap_stay");
    rd(OFF_CAP_HIGH, hi);
    chk("cap_hi", hi, 8'h0f);
    rdchk(OFF_CTRL_STATUS, 8'h20, "cap_clr");
    chk("cap_irq", {7'h0, capture_irq}, 8'h00);
  endtask : t_capture

  // timebase and 32 MHz selections; reload zero so the count wraps naturally
  task automatic t_modes();
    logic [7:0]  c;
    logic [7:0]  h;
    logic [11:0] v;
    logic        p;
    wr(OFF_RELOAD_HIGH, 8'h00);
    wr(OFF_RELOAD_LOW, 8'h00);
    rd(OFF_CHAN_CSR0, h);
    rd(OFF_CNT_LOW, c);
    rd(OFF_CNT_HIGH, h);
    v = {h[3:0], c} + 12'h002;
    wr(OFF_DUTY_LOW0, v[7:0]);
    wr(OFF_DUTY_LOW0 + 8'h01, {4'h0, v[11:8]});
    p = pwm_out[0];
    wr(OFF_CTRL_STATUS, 8'h08);
    lite_en <= 1'b1;
    repeat (32) @(posedge clk);
    lite_en <= 1'b0;
    rdchk(OFF_CNT_LOW, c + 8'h04, "lite_cnt");
    rdchk(OFF_CHAN_CSR0, 8'h02, "lite_cmp");
    chk("lite_pwm", {7'h0, pwm_out[0]}, {7'h0, p});
    wr(OFF_CTRL_STATUS, 8'h18);
    repeat (98) @(posedge clk);
    wr(OFF_CTRL_STATUS, 8'h00);
    rdchk(OFF_CNT_LOW, c + 8'h24, "fast_cnt");
  endtask : t_modes

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n    = 1'b0;
    addr       = 8'h00;
    wdata      = 8'h00;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    fire       = 1'b0;
    lite_en    = 1'b0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_overflow();
    t_pwm();
    t_capture();
    t_modes();
    stop_test();
  end
endmodule : atmr_timer_tb_top
